// [src/tbp_pkg.sv]
package tbp_pkg;
    // Register word offsets on the APB bus.
    localparam logic [7:0] TBP_T0_CFG = 8'h00;
    localparam logic [7:0] TBP_T0_PER = 8'h04;
    localparam logic [7:0] TBP_T1_CFG = 8'h08;
    localparam logic [7:0] TBP_T1_PER = 8'h0C;
    localparam logic [7:0] TBP_SEL = 8'h10;
    localparam logic [7:0] TBP_STAT = 8'h14;
    localparam logic [7:0] TBP_T0_CNT = 8'h18;
    localparam logic [7:0] TBP_T1_CNT = 8'h1C;
    localparam logic [7:0] TBP_CH_BASE = 8'h20;
    localparam logic [7:0] TBP_CH_STRIDE = 8'h10;
    localparam logic [7:0] TBP_CH_CON = 8'h00;
    localparam logic [7:0] TBP_CH_DCH = 8'h04;
    localparam logic [7:0] TBP_CH_DCL = 8'h08;
    localparam logic [7:0] TBP_CH_STS = 8'h0C;
    // Timer configuration field positions.
    localparam int TBP_CFG_EN = 0;
    localparam int TBP_CFG_PRE_LO = 1;
    localparam int TBP_CFG_POST_LO = 3;
    // Channel control field positions.
    localparam int TBP_CON_INV = 0;
    localparam int TBP_CON_OE = 1;
    // Duty low register keeps the two fraction bits here.
    localparam int TBP_DCL_LO = 6;
    // Reset values.
    localparam logic [7:0] TBP_RST_PER = 8'hFF;
    localparam logic [7:0] TBP_RST_DUTY = 8'h00;
    localparam logic [6:0] TBP_RST_CFG = 7'h00;
    // Prescale terminal counts for 1:1, 1:4, 1:16 and 1:64.
    localparam logic [5:0] TBP_PRE_1 = 6'h00;
    localparam logic [5:0] TBP_PRE_4 = 6'h03;
    localparam logic [5:0] TBP_PRE_16 = 6'h0F;
    localparam logic [5:0] TBP_PRE_64 = 6'h3F;
    // Last fraction step within one timer step.
    localparam logic [1:0] TBP_FRAC_LAST = 2'h3;
endpackage : tbp_pkg

// [src/tbp_timebase.sv]
`timescale 1ns/10ps
module tbp_timebase (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [1:0] presc,
    input wire logic [3:0] post,
    input wire logic [7:0] period,
    output logic [9:0] cnt,
    output logic [9:0] cnt_nxt,
    output logic adv,
    output logic wrap,
    output logic post_evt
);
    import tbp_pkg::*;

    logic [5:0] div_r;
    logic [5:0] div_lim;
    logic [3:0] post_r;
    logic at_end;

    // Prescale terminal count for the selected ratio.
    function automatic logic [5:0] pre_lim(input logic [1:0] code);
        case (code)
            2'h0: pre_lim = TBP_PRE_1;
            2'h1: pre_lim = TBP_PRE_4;
            2'h2: pre_lim = TBP_PRE_16;
            default: pre_lim = TBP_PRE_64;
        endcase
    endfunction : pre_lim

    // One step of the ten-bit base per prescaled oscillator period.
    assign div_lim = pre_lim(presc);
    assign adv = en && (div_r >= div_lim);
    // Last fraction step of the period count ends the period.
    assign at_end = (cnt[9:2] == period) && (cnt[1:0] == TBP_FRAC_LAST);
    assign wrap = adv && (at_end || (cnt == 10'h3FF));
    // Timer and fraction bits restart together at the wrap.
    assign cnt_nxt = !adv ? cnt : (wrap ? 10'h000 : cnt + 10'h001);
    // The postscaler only counts wraps for software.
    assign post_evt = wrap && (post_r == post);

    // Prescale divider.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 6'h00;
        end else begin
            div_r <= (adv || !en) ? 6'h00 : div_r + 6'h01;
        end
    end

    // Time base and postscale counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 10'h000;
            post_r <= 4'h0;
        end else begin
            cnt <= cnt_nxt;
            if (wrap) begin
                post_r <= post_evt ? 4'h0 : post_r + 4'h1;
            end
        end
    end
endmodule : tbp_timebase

// [src/tbp_pwm.sv]
// Functional notes
// - Timer clears on the step after it equals the period value.
// - Output goes active at each wrap unless duty is zero.
// - Duty high and low registers load the compare buffers at each wrap.
// - Duty is ten bits: high register, then low register bits 7 and 6.
// - Duty registers may be written anytime; only buffers drive compare.
// - Active pulse lasts duty times oscillator period times prescale.
// - Duty ratio is duty over four times period value plus one.
// - Postscaler never affects period, pulse width or buffer reload.
// - Two fraction bits below the timer form a ten-bit time base.
// - Output clears on duty match; duty at or above period never clears.
// - Invert bit swaps active and inactive output levels.
// - One shared selected timer sets period; each channel has own duty.
// - Drive enable cleared hands the pin back to the port latch.
`timescale 1ns/10ps
module tbp_pwm #(
    parameter int NCH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] port_latch,
    output logic [NCH-1:0] pwm_pin
);
    import tbp_pkg::*;

    // Timer configuration and period registers, one set per timer.
    logic [6:0] t0_cfg_r;
    logic [6:0] t1_cfg_r;
    logic [7:0] t0_per_r;
    logic [7:0] t1_per_r;
    logic timer_select_r;
    logic [1:0] post_flag_r;

    // Time base outputs of both timers.
    logic [9:0] t0_cnt;
    logic [9:0] t1_cnt;
    logic [9:0] t0_cnt_nxt;
    logic [9:0] t1_cnt_nxt;
    logic t0_adv;
    logic t1_adv;
    logic t0_wrap;
    logic t1_wrap;
    logic t0_post;
    logic t1_post;

    // Selected shared time base.
    logic [9:0] sel_cnt_nxt;
    logic [7:0] sel_per;
    logic sel_adv;
    logic sel_wrap;

    // Bus decode.
    logic setup_ph;
    logic wr_acc;
    logic glob_hit;
    logic ch_hit;
    logic [7:0] ch_off;
    logic [7:0] ch_idx;
    logic [7:0] ch_reg;
    logic [31:0] rd_glob;
    logic [31:0] rd_ch;
    logic wr_t0_cfg;
    logic wr_t1_cfg;
    logic wr_t0_per;
    logic wr_t1_per;
    logic wr_sel;
    logic wr_stat;
    logic [1:0] stat_clr;

    // Channel state.
    logic [7:0] dch_r [NCH];
    logic [1:0] dcl_r [NCH];
    logic [9:0] dbuf_r [NCH];
    logic [NCH-1:0] inv_r;
    logic [NCH-1:0] oe_r;
    logic [NCH-1:0] lvl_r;
    logic [NCH-1:0] lvl_nxt;
    logic [NCH-1:0] pin_nxt;
    logic [31:0] rd_mux [NCH];

    // Registers answer in zero wait states.
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [NCH-1:0] pin_r;

    // Checks whether an address names a given word.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Timer A and timer B, each with its own period and prescaler.
    tbp_timebase u_t0 (
        .pclk(pclk),
        .presetn(presetn),
        .en(t0_cfg_r[TBP_CFG_EN]),
        .presc(t0_cfg_r[TBP_CFG_PRE_LO +: 2]),
        .post(t0_cfg_r[TBP_CFG_POST_LO +: 4]),
        .period(t0_per_r),
        .cnt(t0_cnt),
        .cnt_nxt(t0_cnt_nxt),
        .adv(t0_adv),
        .wrap(t0_wrap),
        .post_evt(t0_post)
    );

    tbp_timebase u_t1 (
        .pclk(pclk),
        .presetn(presetn),
        .en(t1_cfg_r[TBP_CFG_EN]),
        .presc(t1_cfg_r[TBP_CFG_PRE_LO +: 2]),
        .post(t1_cfg_r[TBP_CFG_POST_LO +: 4]),
        .period(t1_per_r),
        .cnt(t1_cnt),
        .cnt_nxt(t1_cnt_nxt),
        .adv(t1_adv),
        .wrap(t1_wrap),
        .post_evt(t1_post)
    );

    // One timer is shared by every channel.
    assign sel_cnt_nxt = timer_select_r ? t1_cnt_nxt : t0_cnt_nxt;
    assign sel_per = timer_select_r ? t1_per_r : t0_per_r;
    assign sel_adv = timer_select_r ? t1_adv : t0_adv;
    assign sel_wrap = timer_select_r ? t1_wrap : t0_wrap;

    // APB phase and address decode.
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign glob_hit = hit(paddr, TBP_T0_CFG) || hit(paddr, TBP_T0_PER)
        || hit(paddr, TBP_T1_CFG) || hit(paddr, TBP_T1_PER)
        || hit(paddr, TBP_SEL) || hit(paddr, TBP_STAT)
        || hit(paddr, TBP_T0_CNT) || hit(paddr, TBP_T1_CNT);
    assign ch_off = paddr - TBP_CH_BASE;
    assign ch_idx = ch_off / TBP_CH_STRIDE;
    assign ch_reg = ch_off % TBP_CH_STRIDE;
    assign ch_hit = (paddr >= TBP_CH_BASE) && (ch_idx < 8'(NCH)) && (paddr[1:0] == 2'h0);

    // Write strobes of the timer, selection and status registers.
    assign wr_t0_cfg = wr_acc && hit(paddr, TBP_T0_CFG);
    assign wr_t1_cfg = wr_acc && hit(paddr, TBP_T1_CFG);
    assign wr_t0_per = wr_acc && hit(paddr, TBP_T0_PER);
    assign wr_t1_per = wr_acc && hit(paddr, TBP_T1_PER);
    assign wr_sel = wr_acc && hit(paddr, TBP_SEL);
    assign wr_stat = wr_acc && hit(paddr, TBP_STAT);
    // Status bits written as one are cleared, all others are kept.
    assign stat_clr = wr_stat ? pwdata[1:0] : 2'h0;

    // Global register read data.
    assign rd_glob = hit(paddr, TBP_T0_CFG) ? {25'h0, t0_cfg_r}
        : hit(paddr, TBP_T0_PER) ? {24'h0, t0_per_r}
        : hit(paddr, TBP_T1_CFG) ? {25'h0, t1_cfg_r}
        : hit(paddr, TBP_T1_PER) ? {24'h0, t1_per_r}
        : hit(paddr, TBP_SEL) ? {31'h0, timer_select_r}
        : hit(paddr, TBP_STAT) ? {30'h0, post_flag_r}
        : hit(paddr, TBP_T0_CNT) ? {22'h0, t0_cnt}
        : hit(paddr, TBP_T1_CNT) ? {22'h0, t1_cnt}
        : 32'h0;

    // Channel read mux chain.
    assign rd_ch = rd_mux[NCH-1];

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic sel_me;
            logic wr_con;
            logic wr_dch;
            logic wr_dcl;
            logic [9:0] duty_reg;
            logic full_duty;
            logic match;
            logic [31:0] rd_me;

            // Per channel register decode.
            assign sel_me = ch_hit && (ch_idx == 8'(gi));
            assign wr_con = wr_acc && sel_me && (ch_reg == TBP_CH_CON);
            assign wr_dch = wr_acc && sel_me && (ch_reg == TBP_CH_DCH);
            assign wr_dcl = wr_acc && sel_me && (ch_reg == TBP_CH_DCL);
            // Ten-bit duty from the high byte and two low fraction bits.
            assign duty_reg = {dch_r[gi], dcl_r[gi]};
            // Duty at or above the period value keeps the output active.
            assign full_duty = (dbuf_r[gi][9:2] >= sel_per);
            // Match on the value the base takes at this step, so the
            // pulse spans exactly duty steps.
            assign match = sel_adv && (sel_cnt_nxt == dbuf_r[gi]);
            assign rd_me = (ch_reg == TBP_CH_CON) ? {30'h0, oe_r[gi], inv_r[gi]}
                : (ch_reg == TBP_CH_DCH) ? {24'h0, dch_r[gi]}
                : (ch_reg == TBP_CH_DCL) ? {24'h0, dcl_r[gi], 6'h00}
                : (ch_reg == TBP_CH_STS) ? {22'h0, dbuf_r[gi]}
                : 32'h0;
            if (gi == 0) begin : g_first
                assign rd_mux[gi] = sel_me ? rd_me : 32'h0;
            end else begin : g_rest
                assign rd_mux[gi] = sel_me ? rd_me : rd_mux[gi-1];
            end

            // Waveform: set at wrap unless the new duty is zero, clear on
            // match; the ratio follows as duty over four times (period value plus one) steps.
            assign lvl_nxt[gi] = sel_wrap ? (duty_reg != 10'h000)
                : (match && !full_duty) ? 1'b0
                : lvl_r[gi];
            // Pin drive: level xor the invert bit, or the port latch when released.
            assign pin_nxt[gi] = oe_r[gi] ? (lvl_r[gi] ^ inv_r[gi])
                : port_latch[gi];

            // Software duty registers, writable at any time.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dch_r[gi] <= TBP_RST_DUTY;
                    dcl_r[gi] <= 2'h0;
                end else begin
                    if (wr_dch) begin
                        dch_r[gi] <= pwdata[7:0];
                    end
                    if (wr_dcl) begin
                        dcl_r[gi] <= pwdata[TBP_DCL_LO +: 2];
                    end
                end
            end

            // Compare buffer reloads only at the wrap.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dbuf_r[gi] <= 10'h000;
                end else if (sel_wrap) begin
                    dbuf_r[gi] <= duty_reg;
                end
            end

            // Channel control bits.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    inv_r[gi] <= 1'b0;
                    oe_r[gi] <= 1'b0;
                end else if (wr_con) begin
                    inv_r[gi] <= pwdata[TBP_CON_INV];
                    oe_r[gi] <= pwdata[TBP_CON_OE];
                end
            end
        end
    endgenerate

    // Internal waveform level of every channel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= '0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // Pin stage, so that every pin comes straight from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= '0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    // Timer A configuration: enable, prescale and postscale.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_cfg_r <= TBP_RST_CFG;
        end else if (wr_t0_cfg) begin
            t0_cfg_r <= pwdata[6:0];
        end
    end

    // Timer B configuration: enable, prescale and postscale.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_cfg_r <= TBP_RST_CFG;
        end else if (wr_t1_cfg) begin
            t1_cfg_r <= pwdata[6:0];
        end
    end

    // Timer A period value; a lower value than the count runs on to the top.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_per_r <= TBP_RST_PER;
        end else if (wr_t0_per) begin
            t0_per_r <= pwdata[7:0];
        end
    end

    // Timer B period value; a lower value than the count runs on to the top.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_per_r <= TBP_RST_PER;
        end else if (wr_t1_per) begin
            t1_per_r <= pwdata[7:0];
        end
    end

    // Shared timer choice for all channels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_select_r <= 1'b0;
        end else if (wr_sel) begin
            timer_select_r <= pwdata[0];
        end
    end

    // Postscale flags: write one to clear, a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_flag_r <= 2'h0;
        end else begin
            post_flag_r <= (post_flag_r & ~stat_clr) | {t1_post, t0_post};
        end
    end

    // APB answer: data and error are prepared in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= 1'b1;
            if (setup_ph) begin
                pslverr_r <= !(glob_hit || ch_hit);
                prdata_r <= pwrite ? 32'h0 : (glob_hit ? rd_glob : rd_ch);
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pwm_pin = pin_r;
endmodule : tbp_pwm

// [bench/tbp_pwm_sva.sv]
`timescale 1ns/10ps
module tbp_pwm_sva #(
    parameter int NCH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NCH-1:0] port_latch,
    input wire logic [NCH-1:0] pwm_pin
);
    logic oe_r;
    logic oe_d_r;
    logic up_r;
    wire wr_con0 = psel && penable && pwrite && paddr == 8'h20;
    wire unmapped = paddr >= 8'(32 + 16 * NCH) || paddr[1:0] != 2'h0;
    // Shadow of channel 0 drive enable; up_r marks the pin stage as settled after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_r <= 1'b0;
            oe_d_r <= 1'b0;
            up_r <= 1'b0;
        end else begin
            oe_r <= wr_con0 ? pwdata[1] : oe_r;
            oe_d_r <= oe_r;
            up_r <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // One complete bus transfer: setup then access.
    sequence s_xfer;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_read(logic [7:0] a);
        s_xfer ##0 (!pwrite && paddr == a);
    endsequence
    a_ready_high: assert property (s_xfer |-> pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (s_xfer ##0 unmapped |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (s_xfer ##0 !unmapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_err_zero_data: assert property (s_xfer ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_dcl_field: assert property (s_read(8'h28) |-> prdata[5:0] == 6'h0 && prdata[31:8] == 24'h0)
        else $error("duty low register shows bits outside 7:6");
    a_count_width: assert property (s_read(8'h18) |-> prdata[31:10] == 22'h0)
        else $error("time base wider than ten bits");
    a_pin_release: assert property (up_r && !oe_r && !oe_d_r |-> pwm_pin[0] == $past(port_latch[0]))
        else $error("released pin does not follow port latch");
    a_reset_idle: assert property ($rose(presetn) |-> pwm_pin == '0)
        else $error("pin active right after reset");
endmodule : tbp_pwm_sva

// [bench/tbp_load.sv]
`timescale 1ns/10ps
module tbp_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    logic [15:0] run_r;
    logic [15:0] hi_r;
    logic pin_d;
    // Measures rise-to-rise period and high time of the pin it is driven by.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 16'h0000;
            hi_r <= 16'h0000;
            pin_d <= 1'b0;
            hi_len <= 16'h0000;
            per_len <= 16'h0000;
        end else begin
            pin_d <= pin;
            run_r <= (pin && !pin_d) ? 16'h0001 : run_r + 16'h0001;
            hi_r <= (pin && !pin_d) ? 16'h0001 : hi_r + 16'(pin);
            if (pin && !pin_d) begin
                per_len <= run_r;
                hi_len <= hi_r;
            end
        end
    end
endmodule : tbp_load

// [bench/tbp_pwm_bench.sv]
`timescale 1ns/10ps
module tbp_pwm_bench;
    import tbp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] port_latch = 2'h0;
    logic [1:0] pwm_pin;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [31:0] v;
    logic err_seen;
    int errors = 0;
    int check_count = 0;
    tbp_pwm #(.NCH(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_latch(port_latch), .pwm_pin(pwm_pin));
    tbp_load load (.pclk(pclk), .presetn(presetn), .pin(pwm_pin[0]), .hi_len(hi_len),
        .per_len(per_len));
    // Clock of 100 ns period.
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bus transfer held until pready is sampled high; read data taken at that edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle
    // Counts high samples of one pin over n cycles, sampled mid-cycle.
    task automatic highs(input int ch, input int n, output logic [31:0] c);
        c = 0;
        repeat (n) begin
            @(negedge pclk);
            c = c + 32'(pwm_pin[ch] === 1'b1);
        end
        @(posedge pclk);
    endtask : highs
    task automatic t_reset;
        apb(1'b0, TBP_T0_PER, 0);
        chk(v, 32'(TBP_RST_PER));
        apb(1'b0, 8'h24, 0);
        chk(v, 32'h0);
        chk(32'(err_seen), 32'h0);
        apb(1'b0, 8'h28, 0);
        chk(v, 32'h0);
        apb(1'b0, 8'h2C, 0);
        chk(v, 32'h0);
        apb(1'b1, 8'h50, 32'h1);
        chk(32'(err_seen), 32'h1);
        apb(1'b0, 8'h50, 0);
        chk(v, 32'h0);
        chk(32'(err_seen), 32'h1);
        $display("Test reset done");
    endtask : t_reset
    task automatic t_release;
        port_latch <= 2'h1;
        idle(3);
        chk(32'(pwm_pin), 32'h1);
        port_latch <= 2'h2;
        idle(3);
        chk(32'(pwm_pin), 32'h2);
        $display("Test release done");
    endtask : t_release
    // Period 1 with duty 2, then prescale 1:4, then 1:4 with full postscale.
    task automatic t_timing;
        apb(1'b1, TBP_T0_PER, 32'h1);
        apb(1'b1, 8'h28, 32'h80);
        apb(1'b1, 8'h20, 32'h2);
        apb(1'b1, TBP_T0_CFG, 32'h1);
        idle(40);
        chk(32'(per_len), 32'd8);
        chk(32'(hi_len), 32'd2);
        apb(1'b0, TBP_T0_CNT, 0);
        chk(32'(v[31:3]), 32'h0);
        apb(1'b1, TBP_T0_CFG, 32'h3);
        idle(100);
        chk(32'(per_len), 32'd32);
        chk(32'(hi_len), 32'd8);
        apb(1'b1, TBP_T0_CFG, 32'h7B);
        idle(100);
        chk(32'(per_len), 32'd32);
        chk(32'(hi_len), 32'd8);
        $display("Test timing done");
    endtask : t_timing
    task automatic t_levels;
        apb(1'b1, TBP_T0_CFG, 32'h1);
        apb(1'b1, 8'h24, 32'h1);
        idle(20);
        highs(0, 16, v);
        chk(v, 32'd16);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h28, 32'h0);
        idle(20);
        highs(0, 16, v);
        chk(v, 32'd0);
        apb(1'b1, 8'h28, 32'hC0);
        idle(20);
        highs(0, 16, v);
        chk(v, 32'd6);
        apb(1'b1, 8'h20, 32'h3);
        idle(20);
        highs(0, 16, v);
        chk(v, 32'd10);
        apb(1'b1, 8'h20, 32'h2);
        $display("Test levels done");
    endtask : t_levels
    // Long period: a duty write must wait for the wrap before it reaches the buffer.
    task automatic t_buffer;
        apb(1'b1, TBP_T0_PER, 32'hFF);
        idle(1100);
        apb(1'b1, 8'h24, 32'h40);
        apb(1'b0, 8'h2C, 0);
        chk(v, 32'h3);
        idle(2100);
        apb(1'b0, 8'h2C, 0);
        chk(v, 32'h103);
        chk(32'(hi_len), 32'h103);
        apb(1'b0, TBP_STAT, 0);
        chk(v, 32'h1);
        apb(1'b1, TBP_STAT, 32'h1);
        apb(1'b0, TBP_STAT, 0);
        chk(v, 32'h0);
        $display("Test buffer done");
    endtask : t_buffer
    task automatic t_select;
        apb(1'b1, TBP_T1_PER, 32'h3);
        apb(1'b1, TBP_T1_CFG, 32'h1);
        apb(1'b1, 8'h34, 32'h1);
        apb(1'b1, 8'h30, 32'h2);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, TBP_SEL, 32'h1);
        idle(1100);
        chk(32'(per_len), 32'd16);
        highs(1, 32, v);
        chk(v, 32'd8);
        $display("Test select done");
    endtask : t_select
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // Main sequence after a two-cycle reset.
    initial begin
        idle(2);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_release();
        t_timing();
        t_levels();
        t_buffer();
        t_select();
        report_and_stop();
    end
    // Watchdog well beyond the roughly 5000 cycles the tests need.
    initial begin
        idle(20000);
        errors++;
        report_and_stop();
    end
endmodule : tbp_pwm_bench
bind tbp_pwm tbp_pwm_sva #(.NCH(NCH)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_latch(port_latch), .pwm_pin(pwm_pin));
